// file: srfba_aligner.v
// Purpose: Receive frame and byte boundary detector with aligned byte output
// Assumes: Serial bits arrive one per core_clk_i with a bit strobe; byte strobe marks
//          parallel_out_clock cycles
// Notes: Bit clock is recovered or reference_clock_in, chosen outside this block
//
// Overview of operation
// - Rising edge of out-of-frame request arms search; it stays on while request high.
// - First A1 byte fixes byte boundary; third A2 byte fixes frame boundary and is the output byte marked by the frame pulse.
// - Frame pulse high for one core_clk_i cycle, the cycle after the byte strobe that puts that A2 byte on the bus.
// - Search stops when first frame found (third A2 byte matched) and request low, whichever later.
// - Serial input reaches parallel bus within 1 to 2 output cycles (8 to 15 bit cycles after its first bit is sampled).
// - In bypass, bits are sampled on core_clk_i with bit_strobe_i, the same as in normal mode.
`timescale 1ns/10ps
`default_nettype none
`include "srfba_regs.vh"
module srfba_aligner
(
   // Clock and reset
   input wire core_clk_i,
   input wire sys_rst_i,
   // Serial side
   input wire serial_receive_data_i,
   input wire diag_loop_data_i,
   input wire diag_loop_sel_i,
   input wire bit_strobe_i,
   // Byte timing and control
   input wire byte_strobe_i,
   input wire out_of_frame_request_i,
   // Parallel side
   output reg [7:0] parallel_out_bus_o,
   output reg frame_pulse_o,
   output reg search_active_o
);
   localparam ST_IDLE = 3'b001;
   localparam ST_A1 = 3'b010;
   localparam ST_A2 = 3'b100;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [14:0] win_r;
   reg [`SRFBA_OFF_W-1:0] off_r;
   reg [`SRFBA_OFF_W-1:0] bitcnt_r;
   reg [`SRFBA_CNT_W-1:0] run_r;
   reg [`SRFBA_CNT_W-1:0] run_nxt;
   reg oof_d_r;
   reg armed_r;
   reg pulsed_r;
   reg [7:0] byte_r;
   reg fp_pend_r;
   reg fp_pend_nxt;
   reg [`SRFBA_OFF_W-1:0] lock_off_nxt;
   wire in_bit;
   wire [14:0] win_nxt;
   wire a1_hit;
   wire a2_hit;
   wire [2:0] a1_off;
   wire [2:0] a2_off;
   wire byte_done;
   wire oof_rise;
   wire hunting;
   wire a1_here;
   wire a2_here;
   wire evaluate;
   wire stop_req;
   wire pend_set;
   function [7:0] pick_byte;
      input [14:0] w;
      input [2:0] o;
      begin
         pick_byte = w[o +: 8];
      end
   endfunction
   // Bypass sampling is done by the caller's bit strobe
   assign in_bit = diag_loop_sel_i ? diag_loop_data_i : serial_receive_data_i;
   assign win_nxt = {win_r[13:0], in_bit};
   assign byte_done = bit_strobe_i && (bitcnt_r == off_r);
   assign oof_rise = out_of_frame_request_i && !oof_d_r;
   // Hunting until the first A1 fixes the byte phase
   assign hunting = (state_r == ST_A1) && (run_r == `SRFBA_CNT_ZERO);
   assign a1_here = a1_hit && (a1_off == `SRFBA_OFF_ZERO);
   assign a2_here = a2_hit && (a2_off == `SRFBA_OFF_ZERO);
   // Every bit while hunting, else only on byte boundaries
   assign evaluate = bit_strobe_i && armed_r && (hunting || byte_done);
   assign stop_req = armed_r && pulsed_r && !out_of_frame_request_i;
   assign pend_set = evaluate && fp_pend_nxt && !oof_rise && !stop_req;
   srfba_pattern_match #(.PATTERN(`SRFBA_A1_BYTE)) u_a1
   (
      .win_i(win_nxt),
      .hit_o(a1_hit),
      .off_o(a1_off)
   );
   srfba_pattern_match #(.PATTERN(`SRFBA_A2_BYTE)) u_a2
   (
      .win_i(win_nxt),
      .hit_o(a2_hit),
      .off_o(a2_off)
   );
   // Pattern search state machine
   always @*
   begin
      state_nxt = state_r;
      run_nxt = run_r;
      fp_pend_nxt = 1'b0;
      lock_off_nxt = off_r;
      case (state_r)
         ST_IDLE:
         begin
            run_nxt = `SRFBA_CNT_ZERO;
         end
         ST_A1:
         begin
            if (hunting)
            begin
               // Boundary is where the match ended, counted back from now
               if (a1_hit)
               begin
                  lock_off_nxt = bitcnt_r - a1_off;
                  run_nxt = `SRFBA_CNT_ONE;
               end
            end
            else if (a1_here)
            begin
               run_nxt = (run_r == `SRFBA_A1_RUN) ? run_r : run_r + `SRFBA_CNT_ONE;
            end
            else if (a2_here && run_r == `SRFBA_A1_RUN)
            begin
               state_nxt = ST_A2;
               run_nxt = `SRFBA_CNT_ONE;
            end
            else
            begin
               run_nxt = `SRFBA_CNT_ZERO;
            end
         end
         ST_A2:
         begin
            if (a2_here)
            begin
               run_nxt = run_r + `SRFBA_CNT_ONE;
               if (run_nxt == `SRFBA_A2_HIT)
               begin
                  fp_pend_nxt = 1'b1;
                  state_nxt = ST_A1;
                  run_nxt = `SRFBA_CNT_ZERO;
               end
            end
            else
            begin
               state_nxt = ST_A1;
               run_nxt = `SRFBA_CNT_ZERO;
            end
         end
         default:
         begin
            state_nxt = ST_IDLE;
         end
      endcase
   end
   always @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         state_r <= ST_IDLE;
         win_r <= `SRFBA_WIN_ZERO;
         off_r <= `SRFBA_OFF_ZERO;
         bitcnt_r <= `SRFBA_OFF_ZERO;
         run_r <= `SRFBA_CNT_ZERO;
         oof_d_r <= 1'b0;
         armed_r <= 1'b0;
         pulsed_r <= 1'b0;
         byte_r <= `SRFBA_BYTE_ZERO;
         fp_pend_r <= 1'b0;
         parallel_out_bus_o <= `SRFBA_BYTE_ZERO;
         frame_pulse_o <= 1'b0;
         search_active_o <= 1'b0;
      end
      else
      begin
         oof_d_r <= out_of_frame_request_i;
         if (oof_rise)
         begin
            armed_r <= 1'b1;
            pulsed_r <= 1'b0;
            state_r <= ST_A1;
            run_r <= `SRFBA_CNT_ZERO;
         end
         else if (stop_req)
         begin
            armed_r <= 1'b0;
            state_r <= ST_IDLE;
         end
         else if (evaluate)
         begin
            state_r <= state_nxt;
            run_r <= run_nxt;
            off_r <= lock_off_nxt;
            if (fp_pend_nxt)
            begin
               pulsed_r <= 1'b1;
            end
         end
         search_active_o <= armed_r;
         if (bit_strobe_i)
         begin
            win_r <= win_nxt;
            bitcnt_r <= bitcnt_r + `SRFBA_BIT_ONE;
         end
         // Aligned byte captured at its last bit
         if (byte_done)
         begin
            byte_r <= pick_byte(win_nxt, `SRFBA_OFF_ZERO);
         end
         // New pend wins over the strobe that clears an old one
         if (pend_set)
         begin
            fp_pend_r <= 1'b1;
         end
         else if (byte_strobe_i)
         begin
            fp_pend_r <= 1'b0;
         end
         // Byte moves to bus on next output cycle
         if (byte_strobe_i)
         begin
            parallel_out_bus_o <= byte_r;
            frame_pulse_o <= fp_pend_r;
         end
         else
         begin
            frame_pulse_o <= 1'b0;
         end
      end
   end
endmodule // srfba_aligner
`default_nettype wire

// file: srfba_chk.sv
// Purpose: Port checker for the frame aligner
// Assumes: Bound to srfba_aligner
// Notes: One clock domain
`timescale 1ns/10ps
`default_nettype none
`include "srfba_regs.vh"
module srfba_chk
(
   // Clock and reset
   input wire core_clk_i,
   input wire sys_rst_i,
   // Inputs
   input wire byte_strobe_i,
   input wire out_of_frame_request_i,
   // Outputs
   input wire [7:0] parallel_out_bus_o,
   input wire frame_pulse_o,
   input wire search_active_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_arm; $rose(out_of_frame_request_i); endsequence
   sequence s_on; ##[1:3] search_active_o; endsequence
   property p_arm; s_arm |-> s_on; endproperty
   a_arm: assert property (p_arm) else $error("search not armed");
   property p_hold; search_active_o && out_of_frame_request_i |=> search_active_o; endproperty
   a_hold: assert property (p_hold) else $error("search dropped");
   property p_a2; frame_pulse_o |-> parallel_out_bus_o == `SRFBA_A2_BYTE; endproperty
   a_a2: assert property (p_a2) else $error("pulse without A2");
   property p_one; frame_pulse_o |=> !frame_pulse_o; endproperty
   a_one: assert property (p_one) else $error("pulse too long");
   property p_stop; $fell(search_active_o) |-> !$past(out_of_frame_request_i); endproperty
   a_stop: assert property (p_stop) else $error("search ended early");
   property p_only; frame_pulse_o |-> $past(search_active_o); endproperty
   a_only: assert property (p_only) else $error("pulse while idle");
   property p_bus; $changed(parallel_out_bus_o) |-> $past(byte_strobe_i); endproperty
   a_bus: assert property (p_bus) else $error("bus off strobe");
endmodule // srfba_chk
bind srfba_aligner srfba_chk srfba_chk_inst (.*);
`default_nettype wire

// file: srfba_pattern_match.v
// Purpose: Finds a given byte at any bit offset of a 15-bit window
// Assumes: Window bit 14 is the oldest bit
// Notes: Combinational, lowest offset wins
`timescale 1ns/10ps
`default_nettype none
module srfba_pattern_match
#(
   parameter [7:0] PATTERN = 8'hF6
)
(
   // Window
   input wire [14:0] win_i,
   // Result
   output reg hit_o,
   output reg [2:0] off_o
);
   integer k;
   always @*
   begin
      hit_o = 1'b0;
      off_o = 3'h0;
      for (k = 7; k >= 0; k = k - 1)
      begin
         if (win_i[k +: 8] == PATTERN)
         begin
            hit_o = 1'b1;
            off_o = k[2:0];
         end
      end
   end
endmodule // srfba_pattern_match
`default_nettype wire

// file: srfba_regs.vh
// Purpose: Constants for the receive frame and byte aligner
// Assumes: Plain Verilog-2005 includes
// Notes: Definitions only
`ifndef SRFBA_REGS_VH
`define SRFBA_REGS_VH
`define SRFBA_A1_BYTE 8'hF6
`define SRFBA_A2_BYTE 8'h28
`define SRFBA_A1_RUN 4'h3
`define SRFBA_A2_HIT 4'h3
`define SRFBA_CNT_W 4
`define SRFBA_OFF_W 3
`define SRFBA_CNT_ZERO 4'h0
`define SRFBA_CNT_ONE 4'h1
`define SRFBA_OFF_ZERO 3'h0
`define SRFBA_BYTE_ZERO 8'h00
`define SRFBA_WIN_ZERO 15'h0000
`define SRFBA_BIT_ONE 3'h1
`endif

// file: srfba_st_model.sv
// Purpose: Section terminator model driving the request
// Assumes: Frame length shortened by parameter
// Notes: Drives at falling edge
`timescale 1ns/10ps
`default_nettype none
module srfba_st_model
#(
   parameter FRAME_CYCLES = 128
)
(
   // Clock and reset
   input wire core_clk_i,
   input wire sys_rst_i,
   // Control
   input wire start_i,
   input wire frame_pulse_i,
   // Request
   output reg out_of_frame_request_o
);
   reg req_r = 1'b0;
   integer cnt_r = 0;
   always @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         req_r <= 1'b0;
      else if (start_i)
      begin
         req_r <= 1'b1;
         cnt_r <= 0;
      end
      else if (req_r && (frame_pulse_i || cnt_r != 0))
      begin
         cnt_r <= cnt_r + 1;
         if (cnt_r == FRAME_CYCLES)
            req_r <= 1'b0;
      end
   end
   always @(negedge core_clk_i)
      out_of_frame_request_o <= req_r;
endmodule // srfba_st_model
`default_nettype wire

// file: srfba_tb_top.sv
// Purpose: Bench for the frame aligner
// Assumes: One bit per clock
// Notes: Inputs change at falling edge
`timescale 1ns/10ps
`default_nettype none
`include "srfba_regs.vh"
module srfba_tb_top;
   reg core_clk_i = 1'b0;
   reg sys_rst_i = 1'b1;
   reg serial_receive_data_i = 1'b0;
   reg diag_loop_data_i = 1'b1;
   reg diag_loop_sel_i = 1'b0;
   reg byte_strobe_i = 1'b0;
   reg go = 1'b0;
   reg [2:0] ph = 3'h0;
   reg [7:0] last = 8'h00;
   wire bit_strobe_i = 1'b1;
   wire out_of_frame_request_i;
   wire [7:0] parallel_out_bus_o;
   wire frame_pulse_o;
   wire search_active_o;
   integer pulses = 0;
   integer miscompares = 0;
   integer checks_done = 0;
   integer i;
   initial forever #5 core_clk_i = ~core_clk_i;
   srfba_aligner srfba_aligner_inst (.*);
   srfba_st_model #(.FRAME_CYCLES(48)) srfba_st_model_inst (.core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i), .start_i(go), .frame_pulse_i(frame_pulse_o),
      .out_of_frame_request_o(out_of_frame_request_i));
   always @(negedge core_clk_i)
   begin
      ph <= ph + 3'h1;
      byte_strobe_i <= (ph == 3'h7);
   end
   always @(posedge core_clk_i)
   begin
      if (frame_pulse_o === 1'b1)
      begin
         pulses = pulses + 1;
         last = parallel_out_bus_o;
      end
   end
   task check(input [7:0] seen, input [7:0] exp);
   begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("ERROR %0t got %h want %h", $time, seen, exp);
      end
   end
   endtask
   task tx(input b);
   begin
      @(negedge core_clk_i);
      serial_receive_data_i = diag_loop_sel_i ? ~b : b;
      diag_loop_data_i = diag_loop_sel_i ? b : ~b;
   end
   endtask
   task frame(input integer skip);
      integer k;
   begin
      for (k = 0; k < skip; k = k + 1) tx(1'b0);
      for (k = 0; k < 80; k = k + 1) tx(k < 24 ? 8'hF6 >> (7 - k % 8) : k < 48 ?
         8'h28 >> (7 - k % 8) : 1'b0);
   end
   endtask
   task t_frame(input lp, input integer skip);
      integer n;
   begin
      @(negedge core_clk_i);
      diag_loop_sel_i = lp;
      go = 1'b1;
      @(negedge core_clk_i);
      go = 1'b0;
      repeat (4) @(negedge core_clk_i);
      check(search_active_o, 1'b1);
      n = pulses;
      frame(skip);
      check(8'(pulses - n), 8'h01);
      check(last, `SRFBA_A2_BYTE);
      check(search_active_o, 1'b1);
      for (i = 0; i < 100 && out_of_frame_request_i; i = i + 1) @(negedge core_clk_i);
      repeat (4) @(negedge core_clk_i);
      check(search_active_o, 1'b0);
      frame(skip);
      check(8'(pulses - n), 8'h01);
      $display("test done loopback %0d", lp);
   end
   endtask
   task stop_test;
   begin
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end
   endtask
   initial
   begin
      repeat (20) @(negedge core_clk_i);
      sys_rst_i = 1'b0;
      t_frame(1'b0, 3);
      t_frame(1'b1, 5);
      stop_test;
   end
   initial
   begin
      #30000;
      miscompares = miscompares + 1;
      stop_test;
   end
endmodule // srfba_tb_top
`default_nettype wire
